// file: design/tec_defs.svh
// Purpose: constants of the three-axis encoder counter (offsets, fields, resets, timing)
// Assumes: 25 MHz system clock
// Notes:   register offsets are byte addresses of 32-bit words
`ifndef TEC_DEFS_SVH
`define TEC_DEFS_SVH

// clock rate
`define TEC_CLK_HZ          25000000

// register byte offsets
`define TEC_OFS_COUNT0      8'h00
`define TEC_OFS_COUNT1      8'h04
`define TEC_OFS_COUNT2      8'h08
`define TEC_OFS_CHCFG       8'h0C
`define TEC_OFS_DICFG       8'h10
`define TEC_OFS_TIMER       8'h14
`define TEC_OFS_ISTAT       8'h18
`define TEC_OFS_IMASK       8'h1C

// channel config fields, four bits per channel: mode[1:0], mult[3:2]
`define TEC_CHCFG_CH_W      4
`define TEC_CHCFG_CHAIN     12
`define TEC_CHCFG_SMP_LSB   13
`define TEC_CHCFG_W         15
`define TEC_CHCFG_RST       15'h0000

// timer fields
`define TEC_TMR_MULT_LSB    0
`define TEC_TMR_BASE_LSB    8
`define TEC_TMR_EN          10
`define TEC_TMR_W           11
`define TEC_TMR_RST         11'h000

// interrupt status layout
`define TEC_INT_OVF_LSB     0
`define TEC_INT_UNF_LSB     3
`define TEC_INT_DI_LSB      6
`define TEC_INT_TMR         11
`define TEC_INT_W           12
`define TEC_INT_RST         12'h000

// counter width and reset
`define TEC_CNT_W           24
`define TEC_CNT_RST         24'h000000
`define TEC_DI_N            5

// filter sample clocks, in Hz, and their divide counts (rounded down)
`define TEC_SMP_8M_HZ       8000000
`define TEC_SMP_4M_HZ       4000000
`define TEC_SMP_2M_HZ       2000000
`define TEC_SMP_8M_DIV      (`TEC_CLK_HZ / `TEC_SMP_8M_HZ)
`define TEC_SMP_4M_DIV      (`TEC_CLK_HZ / `TEC_SMP_4M_HZ)
`define TEC_SMP_2M_DIV      (`TEC_CLK_HZ / `TEC_SMP_2M_HZ)

// interval timer time bases, in Hz, and their cycle counts
`define TEC_TB_1HZ_HZ       1
`define TEC_TB_10HZ_HZ      10
`define TEC_TB_1KHZ_HZ      1000
`define TEC_TB_10KHZ_HZ     10000
`define TEC_TB_1HZ_CYC      (`TEC_CLK_HZ / `TEC_TB_1HZ_HZ)
`define TEC_TB_10HZ_CYC     (`TEC_CLK_HZ / `TEC_TB_10HZ_HZ)
`define TEC_TB_1KHZ_CYC     (`TEC_CLK_HZ / `TEC_TB_1KHZ_HZ)
`define TEC_TB_10KHZ_CYC    (`TEC_CLK_HZ / `TEC_TB_10KHZ_HZ)

`endif

// file: design/tec_pkg.sv
// Purpose: types of the three-axis encoder counter
// Assumes: constants live in tec_defs.svh
// Notes:   enum codes follow the register field encodings by position
package tec_pkg;

  // counting mode of one channel
  typedef enum logic [1:0] {
    MODE_QUAD,
    MODE_PULSE_DIR,
    MODE_UP_DOWN,
    MODE_OFF
  } tec_mode_e;

  // quadrature multiplication
  typedef enum logic [1:0] {
    MULT_X1,
    MULT_X2,
    MULT_X4,
    MULT_RSVD
  } tec_mult_e;

  // per-channel configuration
  typedef struct packed {
    tec_mult_e mult;
    tec_mode_e mode;
  } tec_chan_cfg_s;

  // one encoder input pair
  typedef struct packed {
    logic a;
    logic b;
  } tec_enc_s;

endpackage : tec_pkg

// file: design/tec_channel.sv
// Purpose: noise filter and decoder of one encoder channel
// Assumes: inputs synchronous to clk; sampleEn is a one-cycle pulse
// Notes:   outputs one-cycle count pulses, never both at once
`timescale 1ns/1ps
module tec_channel (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              sampleEn,
  input  wire tec_pkg::tec_enc_s enc,
  input  wire tec_pkg::tec_chan_cfg_s cfg,
  output logic                   stepUp,
  output logic                   stepDn
);
  import tec_pkg::*;

  logic [3:0] histA;
  logic [3:0] histB;
  logic       filtA;
  logic       filtB;

  // filtered level moves only once four samples agree
  wire next_filtA = (&histA) ? 1'b1 : (~|histA) ? 1'b0 : filtA;
  wire next_filtB = (&histB) ? 1'b1 : (~|histB) ? 1'b0 : filtB;

  // edge terms of the filtered inputs
  wire chgA  = next_filtA ^ filtA;
  wire chgB  = next_filtB ^ filtB;
  wire riseA = next_filtA & ~filtA;
  wire riseB = next_filtB & ~filtB;

  // quadrature: A leading B counts up; a double change is a skipped state and is dropped
  wire quadDir  = next_filtA ^ filtB;
  wire quadX4   = chgA ^ chgB;
  wire quadX2   = chgA & ~chgB;
  wire quadX1   = chgA & ~chgB & ~filtB;
  wire quadStep = (cfg.mult == MULT_X4) ? quadX4 :
                  (cfg.mult == MULT_X2) ? quadX2 : quadX1;

  // mode selection
  logic next_up;
  logic next_dn;
  always_comb begin
    next_up = 1'b0;
    next_dn = 1'b0;
    case (cfg.mode)
      MODE_QUAD: begin
        next_up = quadStep & quadDir;
        next_dn = quadStep & ~quadDir;
      end
      MODE_PULSE_DIR: begin
        next_up = riseA & ~next_filtB;
        next_dn = riseA & next_filtB;
      end
      MODE_UP_DOWN: begin
        next_up = riseA & ~riseB;
        next_dn = riseB & ~riseA;
      end
      default: begin
        next_up = 1'b0;
        next_dn = 1'b0;
      end
    endcase
  end

  // sample shift registers
  always_ff @(posedge clk) begin
    if (rst) begin
      histA <= 4'h0;
      histB <= 4'h0;
    end else if (sampleEn) begin
      histA <= {histA[2:0], enc.a};
      histB <= {histB[2:0], enc.b};
    end
  end

  // filtered levels and count pulses
  always_ff @(posedge clk) begin
    if (rst) begin
      filtA  <= 1'b0;
      filtB  <= 1'b0;
      stepUp <= 1'b0;
      stepDn <= 1'b0;
    end else begin
      filtA  <= next_filtA;
      filtB  <= next_filtB;
      stepUp <= next_up;
      stepDn <= next_dn;
    end
  end

endmodule : tec_channel

// file: design/tec_top.sv
// Purpose: three-axis encoder counter with digital inputs and interval timer
// Assumes: single 25 MHz clock, synchronous active-high reset, inputs synchronous
// Notes:   registers on a plain strobe port, read data one cycle after the read strobe
//
// Summary of operation
// - three independent channels, each with a 24-bit count.
// - channel 1 can count channel 0 carries and borrows, giving 48 bits.
// - each channel counts quadrature, pulse plus direction, or up/down pulses.
// - quadrature counting at one, two or four counts per cycle.
// - four-sample noise filter per encoder input, sample rate 8, 4 or 2 MHz.
// - decoding keeps up with 1.0 MHz quadrature and 1.0 MHz pulses.
// - quadrature decoding needs no index signal.
// - five digital inputs; inputs 0 to 2 can each be an index, all can be home sensors.
// - interrupt on digital input, counter wrap, or timer expiry.
// - periodic timer, base 1 Hz to 10 kHz times 1 to 255.
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "tec_defs.svh"
module tec_top #(
  parameter int TB_1HZ_CYCLES   = `TEC_TB_1HZ_CYC,
  parameter int TB_10HZ_CYCLES  = `TEC_TB_10HZ_CYC,
  parameter int TB_1KHZ_CYCLES  = `TEC_TB_1KHZ_CYC,
  parameter int TB_10KHZ_CYCLES = `TEC_TB_10KHZ_CYC
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic [7:0]              addr,
  input  wire logic [31:0]             wdata,
  input  wire logic                    wr,
  input  wire logic                    rd,
  output logic      [31:0]             rdata,
  input  wire tec_pkg::tec_enc_s [2:0] enc,
  input  wire logic [`TEC_DI_N-1:0]    digIn,
  output logic                         irq
);
  import tec_pkg::*;

  localparam int CW = `TEC_CNT_W;
  localparam logic [CW-1:0] CNT_MAX = {CW{1'b1}};

  // registers
  logic [CW-1:0]              count [3];
  logic [`TEC_CHCFG_W-1:0]    chCfg;
  logic [`TEC_DI_N-1:0]       diRole;
  logic [`TEC_DI_N-1:0]       diPrev;
  logic [`TEC_TMR_W-1:0]      tmrCfg;
  logic [`TEC_INT_W-1:0]      intStat;
  logic [`TEC_INT_W-1:0]      intMask;
  logic [4:0]                 smpCnt;
  logic [24:0]                preCnt;
  logic [7:0]                 multCnt;

  // address decode
  wire selCount0 = addr == `TEC_OFS_COUNT0;
  wire selCount1 = addr == `TEC_OFS_COUNT1;
  wire selCount2 = addr == `TEC_OFS_COUNT2;
  wire selChCfg  = addr == `TEC_OFS_CHCFG;
  wire selDiCfg  = addr == `TEC_OFS_DICFG;
  wire selTimer  = addr == `TEC_OFS_TIMER;
  wire selIStat  = addr == `TEC_OFS_ISTAT;
  wire selIMask  = addr == `TEC_OFS_IMASK;
  wire [2:0] wrCount = {3{wr}} & {selCount2, selCount1, selCount0};

  // configuration fields
  wire       chainEn  = chCfg[`TEC_CHCFG_CHAIN];
  wire [1:0] smpSel   = chCfg[`TEC_CHCFG_SMP_LSB +: 2];
  wire [7:0] tmrMult  = tmrCfg[`TEC_TMR_MULT_LSB +: 8];
  wire [1:0] tmrBase  = tmrCfg[`TEC_TMR_BASE_LSB +: 2];
  wire       tmrRun   = tmrCfg[`TEC_TMR_EN] & (tmrMult != 8'h00);

  // filter sample enable; a slower sample clock trades top rate for noise immunity
  // compare is >= so a switch to a shorter divide never lets the count run past and wrap
  wire [4:0] smpDiv = (smpSel == 2'h0) ? 5'(`TEC_SMP_8M_DIV) :
                      (smpSel == 2'h1) ? 5'(`TEC_SMP_4M_DIV) : 5'(`TEC_SMP_2M_DIV);
  wire       smpEn  = smpCnt >= (smpDiv - 5'h01);

  always_ff @(posedge clk) begin
    if (rst || smpEn) smpCnt <= 5'h00;
    else smpCnt <= smpCnt + 5'h01;
  end

  // channel decoders
  logic [2:0] stepUp;
  logic [2:0] stepDn;
  for (genvar i = 0; i < 3; i++) begin : g_chan
    tec_channel u_chan (
      .clk      (clk),
      .rst      (rst),
      .sampleEn (smpEn),
      .enc      (enc[i]),
      .cfg      (tec_chan_cfg_s'(chCfg[i*`TEC_CHCFG_CH_W +: `TEC_CHCFG_CH_W])),
      .stepUp   (stepUp[i]),
      .stepDn   (stepDn[i])
    );
  end

  // digital inputs: rising edge is the active event
  wire [`TEC_DI_N-1:0] diRise = digIn & ~diPrev;
  wire [2:0]           idxClr = diRise[2:0] & diRole[2:0];

  always_ff @(posedge clk) begin
    if (rst) diPrev <= '0;
    else diPrev <= digIn;
  end

  // count sources; chaining feeds channel 0 wraps into channel 1
  // no carry when a load or an index clear overrides the channel 0 step
  wire       ovf0  = stepUp[0] & (count[0] == CNT_MAX) & ~wrCount[0] & ~idxClr[0];
  wire       unf0  = stepDn[0] & (count[0] == '0) & ~wrCount[0] & ~idxClr[0];
  wire [2:0] incEn = {stepUp[2], chainEn ? ovf0 : stepUp[1], stepUp[0]};
  wire [2:0] decEn = {stepDn[2], chainEn ? unf0 : stepDn[1], stepDn[0]};

  // wrap detection; channel 0 wraps are carries, not events, while chained
  logic [2:0] ovfEv;
  logic [2:0] unfEv;
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      ovfEv[i] = incEn[i] & (count[i] == CNT_MAX) & ~wrCount[i] & ~idxClr[i];
      unfEv[i] = decEn[i] & (count[i] == '0) & ~wrCount[i] & ~idxClr[i];
    end
    if (chainEn) begin
      ovfEv[0] = 1'b0;
      unfEv[0] = 1'b0;
    end
  end

  // counters: software load beats index clear beats counting
  always_ff @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      if (rst) count[i] <= `TEC_CNT_RST;
      else if (wrCount[i]) count[i] <= wdata[CW-1:0];
      else if (idxClr[i]) count[i] <= `TEC_CNT_RST;
      else if (incEn[i]) count[i] <= count[i] + 24'h000001;
      else if (decEn[i]) count[i] <= count[i] - 24'h000001;
    end
  end

  // interval timer time base selection
  wire [24:0] tbCycles = (tmrBase == 2'h0) ? 25'(TB_1HZ_CYCLES)  :
                         (tmrBase == 2'h1) ? 25'(TB_10HZ_CYCLES) :
                         (tmrBase == 2'h2) ? 25'(TB_1KHZ_CYCLES) : 25'(TB_10KHZ_CYCLES);
  wire        tbTick   = tmrRun & (preCnt == tbCycles - 25'h0000001);
  wire        tmrExp   = tbTick & (multCnt == tmrMult - 8'h01);
  wire        tmrWr    = wr & selTimer;

  // prescaler and multiplier reload by themselves, so the period repeats
  always_ff @(posedge clk) begin
    if (rst || tmrWr || !tmrRun) begin
      preCnt  <= 25'h0000000;
      multCnt <= 8'h00;
    end else if (tbTick) begin
      preCnt  <= 25'h0000000;
      multCnt <= tmrExp ? 8'h00 : multCnt + 8'h01;
    end else begin
      preCnt  <= preCnt + 25'h0000001;
    end
  end

  // interrupt events; a set in the clearing cycle wins
  wire [`TEC_INT_W-1:0] intEv  = {tmrExp, diRise, unfEv, ovfEv};
  wire [`TEC_INT_W-1:0] intClr = (wr & selIStat) ? wdata[`TEC_INT_W-1:0] : '0;
  wire [`TEC_INT_W-1:0] next_intStat = (intStat & ~intClr) | intEv;

  always_ff @(posedge clk) begin
    if (rst) begin
      intStat <= `TEC_INT_RST;
      intMask <= `TEC_INT_RST;
      irq     <= 1'b0;
    end else begin
      intStat <= next_intStat;
      if (wr && selIMask) intMask <= wdata[`TEC_INT_W-1:0];
      irq     <= |(next_intStat & ((wr && selIMask) ? wdata[`TEC_INT_W-1:0] : intMask));
    end
  end

  // configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      chCfg  <= `TEC_CHCFG_RST;
      diRole <= '0;
      tmrCfg <= `TEC_TMR_RST;
    end else if (wr) begin
      if (selChCfg) chCfg  <= wdata[`TEC_CHCFG_W-1:0];
      if (selDiCfg) diRole <= wdata[`TEC_DI_N-1:0];
      if (selTimer) tmrCfg <= wdata[`TEC_TMR_W-1:0];
    end
  end

  // read selection; unmapped addresses read zero
  wire [31:0] rdSel =
      selCount0 ? {8'h00, count[0]} :
      selCount1 ? {8'h00, count[1]} :
      selCount2 ? {8'h00, count[2]} :
      selChCfg  ? {17'h00000, chCfg} :
      selDiCfg  ? {19'h00000, digIn, 3'h0, diRole} :
      selTimer  ? {21'h000000, tmrCfg} :
      selIStat  ? {20'h00000, intStat} :
      selIMask  ? {20'h00000, intMask} : 32'h00000000;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) rdata <= 32'h00000000;
    else rdata <= rd ? rdSel : 32'h00000000;
  end

endmodule : tec_top

// file: test/tec_top_sva.sv
// Purpose: port-level checks of the encoder counter top
// Assumes: single clock domain, synchronous active-high reset
// Notes:   the mask register is shadowed from the write port
`timescale 1ns/1ps
`include "tec_defs.svh"
module tec_top_sva (
  input wire logic                    clk,
  input wire logic                    rst,
  input wire logic [7:0]              addr,
  input wire logic [31:0]             wdata,
  input wire logic                    wr,
  input wire logic                    rd,
  input wire logic [31:0]             rdata,
  input wire tec_pkg::tec_enc_s [2:0] enc,
  input wire logic [`TEC_DI_N-1:0]    digIn,
  input wire logic                    irq
);
  import tec_pkg::*;
  logic [11:0] maskSh;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // shadow of the interrupt mask, updated on the same edge as the design
  always_ff @(posedge clk) begin
    if (rst) maskSh <= 12'h000;
    else if (wr && addr == `TEC_OFS_IMASK) maskSh <= wdata[11:0];
  end
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data not zero outside the read cycle");
  a_reset_clear: assert property (disable iff (1'b0) rst |=> (rdata == 32'h0 && !irq))
    else $error("reset did not clear outputs");
  a_irq_masked: assert property (maskSh == 12'h000 |-> !irq)
    else $error("interrupt with all sources masked");
  a_di_irq_raise: assert property (|(digIn & ~$past(digIn) & maskSh[10:6]) |-> ##[1:2] irq)
    else $error("unmasked input edge gave no interrupt");
  a_irq_fall_cause: assert property ($fell(irq) |-> $past(rst) ||
    ($past(wr) && ($past(addr) == `TEC_OFS_ISTAT || $past(addr) == `TEC_OFS_IMASK)))
    else $error("interrupt dropped without clear or mask");
  a_count_upper_zero: assert property ($past(rd) && $past(addr) inside {`TEC_OFS_COUNT0,
    `TEC_OFS_COUNT1, `TEC_OFS_COUNT2} |-> rdata[31:24] == 8'h00)
    else $error("count wider than 24 bits");
  a_istat_upper_zero: assert property ($past(rd) && $past(addr) == `TEC_OFS_ISTAT |-> rdata[31:12] == 20'h0)
    else $error("status has bits above its layout");
  a_dicfg_live_inputs: assert property ($past(rd) && $past(addr) == `TEC_OFS_DICFG |-> rdata[12:8] == $past(digIn))
    else $error("input readback does not match pins");
  c_irq_rise: cover property ($rose(irq));
  c_index_edge: cover property ($rose(digIn[0]));
  c_read_nonzero: cover property ($past(rd) && rdata != 32'h0);
endmodule : tec_top_sva
bind tec_top tec_top_sva i_sva (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .enc(enc), .digIn(digIn), .irq(irq));

// file: test/tec_enc_model.sv
// Purpose: behavioural incremental encoders for three channels
// Assumes: levels change just after a rising edge
// Notes:   no index line; a and b are always driven, never released
`timescale 1ns/1ps
module tec_enc_model (
  input  wire logic               clk,
  output tec_pkg::tec_enc_s [2:0] enc
);
  import tec_pkg::*;
  int qs [3] = '{0, 0, 0};
  // encoders come up at rest in state 00
  initial enc = '0;
  // hold one level pair for a given number of clocks
  task automatic setAB(input int ch, input logic a, input logic b, input int hold);
    @(posedge clk);
    enc[ch] <= {a, b};
    repeat (hold - 1) @(posedge clk);
  endtask : setAB
  // gray walk 00,10,11,01 counts up; reverse counts down
  task automatic quad(input int ch, input bit up, input int n, input int hold);
    for (int i = 0; i < n; i++) begin
      qs[ch] = up ? (qs[ch] + 1) % 4 : (qs[ch] + 3) % 4;
      setAB(ch, qs[ch] == 1 || qs[ch] == 2, qs[ch] >= 2, hold);
    end
  endtask : quad
endmodule : tec_enc_model

// file: test/three_axis_encoder_counter_tb_top.sv
// Purpose: self-checking bench of the encoder counter top
// Assumes: timer bases shortened to 40/20/10/5 clocks
// Notes:   levels held 20 clocks so the 8 MHz filter always settles
`timescale 1ns/1ps
`include "tec_defs.svh"
module three_axis_encoder_counter_tb_top;
  import tec_pkg::*;
  localparam int HOLD = 20;
  logic           clk, rst, wr, rd, irq;
  logic [7:0]     addr;
  logic [31:0]    wdata, rdata;
  tec_enc_s [2:0] enc;
  logic [4:0]     digIn;
  int             error_cnt, cmp_count;
  tec_top #(.TB_1HZ_CYCLES(40), .TB_10HZ_CYCLES(20), .TB_1KHZ_CYCLES(10), .TB_10KHZ_CYCLES(5)) i_dut (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .enc(enc), .digIn(digIn), .irq(irq));
  tec_enc_model i_enc (.clk(clk), .enc(enc));
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrReg
  // read data is looked at only in the cycle after the strobe
  task automatic rdReg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rdReg
  task automatic t_reset();
    for (int i = 0; i < 9; i++) rdReg(8'(4 * i), 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask : t_reset
  task automatic t_quad();
    // multiplier code 3 counts as x1, so the walk back below still ends at zero
    for (int m = 0; m < 4; m++) begin
      wrReg(`TEC_OFS_CHCFG, 32'(m << 2));
      wrReg(`TEC_OFS_COUNT0, 32'h0);
      i_enc.quad(0, 1, 4, HOLD);
      repeat (HOLD) @(posedge clk);
      rdReg(`TEC_OFS_COUNT0, (m == 3) ? 32'h1 : 32'(1 << m));
    end
    i_enc.quad(0, 0, 4, HOLD);
    repeat (HOLD) @(posedge clk);
    rdReg(`TEC_OFS_COUNT0, 32'h0);
    rdReg(`TEC_OFS_COUNT1, 32'h0);
  endtask : t_quad
  task automatic t_modes();
    wrReg(`TEC_OFS_CHCFG, 32'h100);
    for (int i = 0; i < 3; i++) begin
      i_enc.setAB(2, 0, i == 2, HOLD);
      i_enc.setAB(2, 1, i == 2, HOLD);
      i_enc.setAB(2, 0, i == 2, HOLD);
    end
    i_enc.setAB(2, 0, 0, HOLD);
    rdReg(`TEC_OFS_COUNT2, 32'h1);
    wrReg(`TEC_OFS_CHCFG, 32'h200);
    wrReg(`TEC_OFS_COUNT2, 32'h0);
    for (int i = 0; i < 4; i++) begin
      i_enc.setAB(2, i < 3, i == 3, HOLD);
      i_enc.setAB(2, 0, 0, HOLD);
    end
    rdReg(`TEC_OFS_COUNT2, 32'h2);
    wrReg(`TEC_OFS_CHCFG, 32'h300);
    i_enc.setAB(2, 1, 0, HOLD);
    i_enc.setAB(2, 0, 0, HOLD);
    rdReg(`TEC_OFS_COUNT2, 32'h2);
  endtask : t_modes
  task automatic t_wrap();
    wrReg(`TEC_OFS_ISTAT, 32'hFFF);
    wrReg(`TEC_OFS_IMASK, 32'h009);
    wrReg(`TEC_OFS_CHCFG, 32'h008);
    wrReg(`TEC_OFS_COUNT0, 32'hFFFFFF);
    i_enc.quad(0, 1, 1, 2 * HOLD);
    rdReg(`TEC_OFS_COUNT0, 32'h0);
    rdReg(`TEC_OFS_ISTAT, 32'h001);
    chk({31'h0, irq}, 32'h1);
    i_enc.quad(0, 0, 1, 2 * HOLD);
    rdReg(`TEC_OFS_COUNT0, 32'hFFFFFF);
    rdReg(`TEC_OFS_ISTAT, 32'h009);
    wrReg(`TEC_OFS_ISTAT, 32'h009);
    rdReg(`TEC_OFS_ISTAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wrReg(`TEC_OFS_CHCFG, 32'h1008);
    wrReg(`TEC_OFS_COUNT1, 32'h0);
    wrReg(`TEC_OFS_COUNT0, 32'hFFFFFF);
    i_enc.quad(0, 1, 1, 2 * HOLD);
    rdReg(`TEC_OFS_COUNT1, 32'h1);
    rdReg(`TEC_OFS_ISTAT, 32'h0);
    i_enc.quad(0, 0, 1, 2 * HOLD);
    rdReg(`TEC_OFS_COUNT1, 32'h0);
  endtask : t_wrap
  // 4 MHz then 2 MHz: short pulses stay under four samples, long ones pass
  task automatic t_filter();
    for (int s = 1; s < 3; s++) begin
      wrReg(`TEC_OFS_CHCFG, 32'h1 | 32'(s << 13));
      wrReg(`TEC_OFS_COUNT0, 32'h0);
      i_enc.setAB(0, 1, 0, 15 * s);
      i_enc.setAB(0, 0, 0, 15 * s);
      rdReg(`TEC_OFS_COUNT0, 32'h0);
      i_enc.setAB(0, 1, 0, 35 * s);
      i_enc.setAB(0, 0, 0, 35 * s);
      rdReg(`TEC_OFS_COUNT0, 32'h1);
    end
  endtask : t_filter
  // 6-clock states give a 24-clock cycle, just above 1.0 MHz quadrature
  task automatic t_rate();
    wrReg(`TEC_OFS_CHCFG, 32'h008);
    wrReg(`TEC_OFS_COUNT0, 32'h0);
    i_enc.quad(0, 1, 16, 6);
    repeat (HOLD) @(posedge clk);
    rdReg(`TEC_OFS_COUNT0, 32'h10);
  endtask : t_rate
  task automatic t_dig();
    wrReg(`TEC_OFS_IMASK, 32'h7C0);
    digIn[3] <= 1'b1;
    repeat (3) @(posedge clk);
    rdReg(`TEC_OFS_ISTAT, 32'h200);
    chk({31'h0, irq}, 32'h1);
    wrReg(`TEC_OFS_ISTAT, 32'h200);
    #1 chk({31'h0, irq}, 32'h0);
    wrReg(`TEC_OFS_DICFG, 32'h01);
    wrReg(`TEC_OFS_COUNT0, 32'h5);
    digIn[0] <= 1'b1;
    repeat (3) @(posedge clk);
    rdReg(`TEC_OFS_COUNT0, 32'h0);
    rdReg(`TEC_OFS_DICFG, 32'h901);
    rdReg(`TEC_OFS_ISTAT, 32'h040);
    wrReg(8'h20, 32'hFFFF);
    rdReg(8'h20, 32'h0);
    rdReg(`TEC_OFS_IMASK, 32'h7C0);
    wrReg(`TEC_OFS_ISTAT, 32'hFFF);
  endtask : t_dig
  // period of 10 kHz base times 20 is 100 clocks here
  task automatic t_timer();
    wrReg(`TEC_OFS_IMASK, 32'h800);
    wrReg(`TEC_OFS_TIMER, 32'h714);
    repeat (50) @(posedge clk);
    rdReg(`TEC_OFS_ISTAT, 32'h0);
    repeat (55) @(posedge clk);
    rdReg(`TEC_OFS_ISTAT, 32'h800);
    chk({31'h0, irq}, 32'h1);
    wrReg(`TEC_OFS_ISTAT, 32'h800);
    repeat (30) @(posedge clk);
    rdReg(`TEC_OFS_ISTAT, 32'h0);
    repeat (60) @(posedge clk);
    rdReg(`TEC_OFS_ISTAT, 32'h800);
    // other bases at multiplier 2: periods of 80, 40 and 20 clocks here
    for (int b = 0; b < 3; b++) begin
      wrReg(`TEC_OFS_TIMER, 32'h402 | 32'(b << 8));
      wrReg(`TEC_OFS_ISTAT, 32'h800);
      repeat ((80 >> b) - 7) @(posedge clk);
      rdReg(`TEC_OFS_ISTAT, 32'h0);
      repeat (5) @(posedge clk);
      rdReg(`TEC_OFS_ISTAT, 32'h800);
    end
    wrReg(`TEC_OFS_TIMER, 32'h0);
  endtask : t_timer
  // mid-run reset with irq high and registers loaded; inputs drop first so release makes no edge
  task automatic t_rst_mid();
    digIn <= 5'h00;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
  endtask : t_rst_mid
  task automatic end_sim();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  // main sequence
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    digIn = 5'h00;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_quad();
    t_modes();
    t_wrap();
    t_filter();
    t_rate();
    t_dig();
    t_timer();
    t_rst_mid();
    end_sim();
  end
  // hang guard, well beyond the few thousand clocks the tests need
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("MISMATCH %0t watchdog expired", $time);
    end_sim();
  end
endmodule : three_axis_encoder_counter_tb_top
